// ---- core/hbt_engine.sv ----
// host blit, packed text and line segment engine with register port
//
// Behaviour
// - drop line leftovers unless source stride zero or packed flag set
// - stride zero: host lines form one stream
// - unpacked alignment uses low three bits
// - dest_coord write comes last and launches
// - full data port stalls host, no loss
// - packed flag: bitmap lines without padding
// - 32-bit words, bit picks fore/background
// - transparent expansion: zero bit leaves pixel
// - packed words fully used, trailing bits dropped
// - bits from byte zero MSB onward
// - fetch pattern row each scan line
// - packed alignment uses low five bits
// - dest and width double buffered
// - horizontal line: count loads width
// - vertical line: count loads height
// - lines use background colour through rop
// - all 256 three-operand raster codes
// - host source select reads data port
// - merge two host words after alignment drop
`timescale 1ns/100ps
`default_nettype none
`include "hbt_regs.svh"

module hbt_engine (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire hbt_pkg::hbt_bus_req_t bus_req,
  output logic [31:0] rdata,
  output logic data_ready,
  output logic busy,
  // frame buffer side
  input wire logic [31:0] dst_data,
  input wire logic [31:0] pat_data,
  output logic [15:0] cur_x,
  output logic [15:0] cur_y,
  output hbt_pkg::hbt_pix_t pix,
  output logic pat_req,
  output logic [15:0] pat_row
);
  import hbt_pkg::*;

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic [31:0] byte_rev32(input logic [31:0] w);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int b = 0; b < 32; b++) begin
      r[b] = w[(b & ~7) + 7 - (b & 7)];
    end
    byte_rev32 = r;
  endfunction : byte_rev32

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] src_pitch;
  logic [31:0] src_align_coord;
  logic [15:0] width_reg;
  logic [15:0] height_reg;
  logic [31:0] fg;
  logic [31:0] bg;
  logic [31:0] pat_base;
  logic [1:0] depth;
  hbt_state_t st;
  hbt_state_t next_st;
  hbt_cmd_t cmd;
  hbt_cmd_t pend;
  logic pend_valid;
  logic [15:0] x_off;
  logic [15:0] y_off;
  logic [63:0] q;
  logic [6:0] cnt;
  logic first;
  logic hw_valid;
  logic [31:0] hw_word;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic wr = bus_req.wr;
  wire logic [15:0] a = bus_req.addr;
  wire logic [31:0] wd = bus_req.wdata;
  wire logic wr_ctrl = wr && hit(a, `HBT_OFF_CTRL);
  wire logic wr_pitch = wr && hit(a, `HBT_OFF_SRC_PITCH);
  wire logic wr_align = wr && hit(a, `HBT_OFF_SRC_ALIGN);
  wire logic wr_width = wr && hit(a, `HBT_OFF_WIDTH);
  wire logic wr_height = wr && hit(a, `HBT_OFF_HEIGHT);
  wire logic wr_fg = wr && hit(a, `HBT_OFF_FG);
  wire logic wr_bg = wr && hit(a, `HBT_OFF_BG);
  wire logic wr_pat = wr && hit(a, `HBT_OFF_PAT_BASE);
  wire logic wr_depth = wr && hit(a, `HBT_OFF_DEPTH);
  wire logic wr_data = wr && hit(a, `HBT_OFF_DATA);
  wire logic dc_wr = wr && (a[15:12] == `HBT_DC_PAGE);
  wire logic [15:0] count = {6'h00, a[11:2]};

  // ----------------------------------------------------------------
  // mode fields
  // ----------------------------------------------------------------
  wire logic [7:0] raster_op_control = ctrl[`HBT_CTRL_ROP_LSB +: 8];
  wire logic [1:0] src_sel = ctrl[`HBT_CTRL_SRC_LSB +: 2];
  wire logic expand = ctrl[`HBT_CTRL_EXPAND];
  wire logic transp = ctrl[`HBT_CTRL_TRANSP];
  wire logic packed_src = ctrl[`HBT_CTRL_PACKED];
  wire logic [1:0] line_mode = ctrl[`HBT_CTRL_LINE_LSB +: 2];
  wire logic pat_en = ctrl[`HBT_CTRL_PAT_EN];
  wire logic hline = (line_mode == `HBT_LINE_HORZ);
  wire logic vline = (line_mode == `HBT_LINE_VERT);
  // line segments take their colour from background, never the port
  wire logic use_host = (src_sel == `HBT_SRC_HOST) && (line_mode == `HBT_LINE_NONE);
  wire logic [2:0] bpp = {1'b0, depth} + 3'd1;
  wire logic [6:0] need = expand ? 7'd1 : {1'b0, bpp, 3'b000};
  wire logic [6:0] skip = packed_src ?
                          {2'b00, src_align_coord[`HBT_ALIGN_PK_W-1:0]} :
                          {1'b0, src_align_coord[`HBT_ALIGN_UNPK_W-1:0], 3'b000};
  wire logic [3:0] be = (depth == 2'd0) ? 4'h1 : (depth == 2'd1) ? 4'h3 :
                        (depth == 2'd2) ? 4'h7 : 4'hf;
  wire logic [31:0] mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};

  // ----------------------------------------------------------------
  // command launch and queue
  // ----------------------------------------------------------------
  wire hbt_cmd_t new_cmd = '{x: wd[15:0], y: wd[31:16],
    width: (hline || packed_src) ? count : width_reg,
    height: vline ? count : height_reg};
  wire logic start_now = dc_wr && (st == HBT_ST_IDLE) && !pend_valid;
  wire logic take = (st == HBT_ST_DONE) && pend_valid;
  wire logic launch = start_now || take;
  wire logic queue_it = dc_wr && !start_now;
  wire logic next_pend_valid = (pend_valid && !take) || queue_it;

  // ----------------------------------------------------------------
  // walk over the rectangle
  // ----------------------------------------------------------------
  wire logic emit = (st == HBT_ST_RUN) && (!use_host || (cnt >= need));
  wire logic x_last = ({1'b0, x_off} + {14'h0000, bpp}) > {1'b0, cmd.width};
  // packed text counts lines, everything else lines minus one
  wire logic [15:0] rows_m1 = (packed_src && use_host) ? cmd.height - 16'h0001 : cmd.height;
  wire logic last_row = (y_off == rows_m1);
  wire logic row_end = emit && x_last;
  wire logic drop_line = use_host && !packed_src && (src_pitch != 16'h0000);

  always_comb begin
    next_st = st;
    case (st)
      HBT_ST_IDLE: begin
        if (start_now) begin
          next_st = HBT_ST_LINE;
        end
      end
      HBT_ST_LINE: begin
        next_st = HBT_ST_RUN;
      end
      HBT_ST_RUN: begin
        if (row_end) begin
          next_st = last_row ? HBT_ST_DONE : HBT_ST_LINE;
        end
      end
      HBT_ST_DONE: begin
        next_st = take ? HBT_ST_LINE : HBT_ST_IDLE;
      end
      default: begin
        next_st = HBT_ST_IDLE;
      end
    endcase
  end

  wire hbt_cmd_t next_cmd = start_now ? new_cmd : take ? pend : cmd;
  wire logic [15:0] next_x_off = launch ? 16'h0000 : !emit ? x_off :
                                 x_last ? 16'h0000 : x_off + {13'h0000, bpp};
  wire logic [15:0] next_y_off = launch ? 16'h0000 : row_end ? y_off + 16'h0001 : y_off;

  // ----------------------------------------------------------------
  // host bit queue: q[0] is the next stream bit
  // ----------------------------------------------------------------
  logic [63:0] mid_q;
  logic [6:0] mid_cnt;
  always_comb begin
    mid_q = q;
    mid_cnt = cnt;
    if (emit && use_host) begin
      mid_q = q >> need;
      mid_cnt = cnt - need;
    end
    if (row_end && drop_line) begin
      mid_q = 64'h0000_0000_0000_0000;
      mid_cnt = 7'd0;
    end
    if (st == HBT_ST_DONE || st == HBT_ST_IDLE) begin
      mid_q = 64'h0000_0000_0000_0000;
      mid_cnt = 7'd0;
    end
  end

  // stream order is byte 0 msb first, so each byte is bit reversed
  wire logic [63:0] stream = {32'h0000_0000, byte_rev32(hw_word)};
  // a word is taken only when the queue runs short, so a line end drops nothing but
  // the leftovers of its own last word; the end of a character also drops a word
  // taken in the cycle of its last pixel
  wire logic load = hw_valid && use_host && (st == HBT_ST_RUN) && (mid_cnt < need);
  wire logic [63:0] next_q = !load ? mid_q : first ? (stream >> skip) :
                             (mid_q | (stream << mid_cnt));
  wire logic [6:0] next_cnt = !load ? mid_cnt : first ? 7'd32 - skip : mid_cnt + 7'd32;
  wire logic next_hw_valid = (hw_valid && !load) || wr_data;

  // ----------------------------------------------------------------
  // source colour and raster operation
  // ----------------------------------------------------------------
  wire logic hbit = q[0];
  wire logic [31:0] src_raw = expand ? (hbit ? fg : bg) :
                              use_host ? byte_rev32(q[31:0]) : bg;
  wire logic [31:0] src_col = src_raw & mask;
  logic [31:0] rop_res;
  for (genvar i = 0; i < 32; i++) begin : g_rop
    assign rop_res[i] = raster_op_control[{pat_data[i], src_col[i], dst_data[i]}];
  end
  wire logic pix_wr = !(expand && transp && !hbit);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire logic [31:0] status = {29'h0, hw_valid, pend_valid, busy};
  wire logic [31:0] rd_mux =
    hit(a, `HBT_OFF_CTRL) ? ctrl :
    hit(a, `HBT_OFF_SRC_PITCH) ? {16'h0000, src_pitch} :
    hit(a, `HBT_OFF_SRC_ALIGN) ? src_align_coord :
    hit(a, `HBT_OFF_WIDTH) ? {16'h0000, width_reg} :
    hit(a, `HBT_OFF_HEIGHT) ? {16'h0000, height_reg} :
    hit(a, `HBT_OFF_FG) ? fg :
    hit(a, `HBT_OFF_BG) ? bg :
    hit(a, `HBT_OFF_PAT_BASE) ? pat_base :
    hit(a, `HBT_OFF_DEPTH) ? {30'h0, depth} :
    hit(a, `HBT_OFF_STATUS) ? status : 32'h0000_0000;
  wire logic [15:0] next_width = wr_width ? wd[15:0] :
                                 (dc_wr && (hline || packed_src)) ? count : width_reg;
  wire logic [15:0] next_height = wr_height ? wd[15:0] : (dc_wr && vline) ? count : height_reg;

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `HBT_CTRL_RST;
      src_pitch <= `HBT_HALF_RST;
      src_align_coord <= `HBT_REG_RST;
      fg <= `HBT_REG_RST;
      bg <= `HBT_REG_RST;
      pat_base <= `HBT_REG_RST;
      depth <= `HBT_DEPTH_RST;
    end else begin
      if (wr_ctrl) ctrl <= wd;
      if (wr_pitch) src_pitch <= wd[15:0];
      if (wr_align) src_align_coord <= wd;
      if (wr_fg) fg <= wd;
      if (wr_bg) bg <= wd;
      if (wr_pat) pat_base <= wd;
      if (wr_depth) depth <= wd[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      width_reg <= `HBT_HALF_RST;
      height_reg <= `HBT_HALF_RST;
      st <= HBT_ST_IDLE;
      cmd <= '0;
      pend <= '0;
      pend_valid <= 1'b0;
      x_off <= `HBT_HALF_RST;
      y_off <= `HBT_HALF_RST;
    end else begin
      width_reg <= next_width;
      height_reg <= next_height;
      st <= next_st;
      cmd <= next_cmd;
      if (queue_it) pend <= new_cmd;
      pend_valid <= next_pend_valid;
      x_off <= next_x_off;
      y_off <= next_y_off;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= 64'h0000_0000_0000_0000;
      cnt <= 7'd0;
      first <= 1'b0;
      hw_valid <= 1'b0;
      hw_word <= `HBT_REG_RST;
      data_ready <= 1'b1;
    end else begin
      q <= next_q;
      cnt <= next_cnt;
      first <= launch || (first && !load);
      hw_valid <= next_hw_valid;
      if (wr_data) hw_word <= wd;
      data_ready <= !next_hw_valid;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `HBT_REG_RST;
      busy <= 1'b0;
      cur_x <= `HBT_HALF_RST;
      cur_y <= `HBT_HALF_RST;
      pix <= '0;
      pat_req <= 1'b0;
      pat_row <= `HBT_HALF_RST;
    end else begin
      rdata <= bus_req.rd ? rd_mux : 32'h0000_0000;
      busy <= (next_st != HBT_ST_IDLE);
      cur_x <= next_cmd.x + next_x_off;
      cur_y <= next_cmd.y + next_y_off;
      pix <= '{valid: emit, wr: pix_wr, x: cur_x, y: cur_y, data: rop_res & mask, be: be};
      pat_req <= (st == HBT_ST_LINE) && pat_en;
      pat_row <= y_off;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_line_drop_left: assert property (row_end && drop_line && !last_row |=> cnt <= 7'd32)
    else $error("leftover host bits kept at line end");
  a_stream_keep: assert property (row_end && use_host && !drop_line && !last_row
      && (cnt > need) |=> cnt >= $past(cnt) - $past(need))
    else $error("host stream lost bits at line end");
  a_first_align: assert property (load && first |=> cnt == 7'd32 - $past(skip))
    else $error("alignment skip not applied");
  a_stall_hold: assert property (hw_valid && !load |=> hw_valid && $stable(hw_word))
    else $error("stalled host word lost");
  a_ready_flag: assert property (wr_data |=> !data_ready ##1 (data_ready || hw_valid))
    else $error("data port ready wrong");
  a_expand_pick: assert property (emit && expand |-> src_col == ((hbit ? fg : bg) & mask))
    else $error("expanded colour wrong");
  a_transp_keep: assert property (emit && expand && transp && !hbit |=> pix.valid && !pix.wr)
    else $error("transparent zero bit wrote pixel");
  a_pat_row: assert property (st == HBT_ST_LINE && pat_en |=> pat_req && pat_row == $past(y_off))
    else $error("pattern row not fetched");
  a_queue_take: assert property (dc_wr && busy |=> pend_valid)
    else $error("busy command not queued");
  a_queue_start: assert property (take |=> st == HBT_ST_LINE && cmd == $past(pend))
    else $error("queued command not started");
  a_hline_width: assert property (dc_wr && hline && !wr_width |=> width_reg == $past(count))
    else $error("line length not in width");
  a_vline_height: assert property (dc_wr && vline && !wr_height |=> height_reg == $past(count))
    else $error("line length not in height");
  a_line_colour: assert property (emit && !use_host && !expand |-> src_col == (bg & mask))
    else $error("line colour is not background");
  a_rop_copy: assert property (emit && raster_op_control == 8'hcc |=> pix.data == $past(src_col))
    else $error("source copy raster op wrong");

  c_packed_text: cover property (launch && packed_src && expand ##[1:200] st == HBT_ST_DONE);
  c_queued_char: cover property (queue_it ##[1:200] take);
  c_host_stall: cover property ((hw_valid && !data_ready && !load) [*3]);
  c_vline: cover property (dc_wr && vline ##[1:100] st == HBT_ST_DONE);

endmodule : hbt_engine

`default_nettype wire

// ---- core/hbt_regs.svh ----
// register offsets, field positions and reset values of the host blit engine
`ifndef HBT_REGS_SVH
`define HBT_REGS_SVH

// ----------------------------------------------------------------
// byte offsets on the register port
// ----------------------------------------------------------------
`define HBT_OFF_CTRL 16'h0000
`define HBT_OFF_SRC_PITCH 16'h0004
`define HBT_OFF_SRC_ALIGN 16'h0008
`define HBT_OFF_WIDTH 16'h000c
`define HBT_OFF_HEIGHT 16'h0010
`define HBT_OFF_FG 16'h0014
`define HBT_OFF_BG 16'h0018
`define HBT_OFF_PAT_BASE 16'h001c
`define HBT_OFF_DEPTH 16'h0020
`define HBT_OFF_STATUS 16'h0024
`define HBT_OFF_DATA 16'h0028
// dest_coord window: addr[15:12] selects it, addr[11:2] is the count field
`define HBT_DC_PAGE 4'h1

// ----------------------------------------------------------------
// raster_op_control fields
// ----------------------------------------------------------------
`define HBT_CTRL_ROP_LSB 0
`define HBT_CTRL_SRC_LSB 8
`define HBT_CTRL_EXPAND 10
`define HBT_CTRL_TRANSP 11
`define HBT_CTRL_PACKED 12
`define HBT_CTRL_LINE_LSB 13
`define HBT_CTRL_PAT_EN 15

// source_select and line mode codes
`define HBT_SRC_FILL 2'h0
`define HBT_SRC_SCREEN 2'h1
`define HBT_SRC_HOST 2'h2
`define HBT_LINE_NONE 2'h0
`define HBT_LINE_HORZ 2'h1
`define HBT_LINE_VERT 2'h2

// alignment widths in bits of src_align_coord
`define HBT_ALIGN_UNPK_W 3
`define HBT_ALIGN_PK_W 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HBT_CTRL_RST 32'h0000_00cc
`define HBT_REG_RST 32'h0000_0000
`define HBT_HALF_RST 16'h0000
`define HBT_DEPTH_RST 2'h0

`endif

// ---- core/hbt_pkg.sv ----
// types shared by the host blit engine
package hbt_pkg;

  // ----------------------------------------------------------------
  // engine states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    HBT_ST_IDLE = 4'b0001,
    HBT_ST_LINE = 4'b0010,
    HBT_ST_RUN = 4'b0100,
    HBT_ST_DONE = 4'b1000
  } hbt_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } hbt_bus_req_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [15:0] x;
    logic [15:0] y;
    logic [31:0] data;
    logic [3:0] be;
  } hbt_pix_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] width;
    logic [15:0] height;
  } hbt_cmd_t;

endpackage : hbt_pkg

// ---- verif/hbt_host.sv ----
// host cpu model: register cycles and stalled data port writes
`timescale 1ns/100ps
`default_nettype none
`include "hbt_regs.svh"

module hbt_host (
  // clock
  input wire logic clk_sys,
  // engine answers
  input wire logic [31:0] rdata,
  input wire logic data_ready,
  // requests
  output var hbt_pkg::hbt_bus_req_t bus_req
);
  import hbt_pkg::*;

  initial bus_req = '0;

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [15:0] addr, output logic [31:0] data);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
    data = rdata;
  endtask : rd

  // waits while the engine holds the port full
  task automatic push(input logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (data_ready !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: `HBT_OFF_DATA, wdata: data};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : push

  // ----------------------------------------------------------------
  // operation setup, launch last
  // ----------------------------------------------------------------
  task automatic setup(input logic [31:0] ctrl, input logic [15:0] width, height, pitch,
                       align);
    wr(`HBT_OFF_CTRL, ctrl);
    wr(`HBT_OFF_DEPTH, 32'h3);
    wr(`HBT_OFF_WIDTH, {16'h0, width});
    wr(`HBT_OFF_HEIGHT, {16'h0, height});
    wr(`HBT_OFF_SRC_PITCH, {16'h0, pitch});
    wr(`HBT_OFF_SRC_ALIGN, {16'h0, align});
  endtask : setup

  task automatic launch(input logic [9:0] count, input logic [15:0] x, y);
    wr({`HBT_DC_PAGE, count, 2'b00}, {y, x});
  endtask : launch

endmodule : hbt_host
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench of the host blit engine
`timescale 1ns/100ps
`default_nettype none
`include "hbt_regs.svh"

module tb_top;
  import hbt_pkg::*;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  hbt_bus_req_t bus_req;
  logic [31:0] rdata, dst_data, pat_data, v;
  logic data_ready, busy, pat_req;
  logic [15:0] cur_x, cur_y, pat_row;
  hbt_pix_t pix;
  hbt_pix_t got[$];
  hbt_pix_t exp[$];
  logic [15:0] rows[$];
  logic [7:0] codes [7] = '{8'h00, 8'hff, 8'haa, 8'hf0, 8'hcc, 8'h5a, 8'h96};
  logic [31:0] fg_col = 32'h00a5_5a01;
  logic [31:0] bg_col = 32'h0012_3400;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2 clk_sys = ~clk_sys;

  // far side: frame buffer and pattern words follow the pixel address
  assign dst_data = {cur_y, cur_x} ^ 32'h5a5a_c3c3;
  assign pat_data = {cur_x, cur_y} ^ 32'h0ff0_3355;

  hbt_engine hbt_engine_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .data_ready(data_ready), .busy(busy), .dst_data(dst_data), .pat_data(pat_data),
    .cur_x(cur_x), .cur_y(cur_y), .pix(pix), .pat_req(pat_req), .pat_row(pat_row)
  );

  hbt_host hbt_host_i (
    .clk_sys(clk_sys), .rdata(rdata), .data_ready(data_ready), .bus_req(bus_req)
  );

  // ----------------------------------------------------------------
  // monitor, timeout and helpers
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (pix.valid === 1'b1) got.push_back(pix);
    if (pat_req === 1'b1) rows.push_back(pat_row);
    if (cycles == 20000) begin
      failures++;
      $display("ERROR %0t timeout", $time);
      results();
    end
  end

  task automatic check(input logic [31:0] seen, want, input string what);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("ERROR %0t %s: seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  function automatic logic [31:0] rop3(input logic [7:0] c, input logic [31:0] p, s, d);
    for (int i = 0; i < 32; i++) begin
      rop3[i] = c[{p[i], s[i], d[i]}];
    end
  endfunction : rop3

  // expected line pixel at one address, from the far-side words there
  function automatic logic [31:0] rop_at(input logic [7:0] c, input logic [15:0] x, y);
    rop_at = rop3(c, {x, y} ^ 32'h0ff0_3355, bg_col, {y, x} ^ 32'h5a5a_c3c3);
  endfunction : rop_at

  task automatic ex(input logic [15:0] x, y, input logic w, input logic [31:0] d);
    exp.push_back('{valid: 1'b1, wr: w, x: x, y: y, data: d, be: 4'hf});
  endtask : ex

  // expanded pixels of one line, msb first
  task automatic bits(input logic [15:0] x, y, input int n, input logic [7:0] b,
                      input logic tr);
    for (int i = 0; i < n; i++) begin
      ex(x + 16'(4 * i), y, tr ? b[7 - i] : 1'b1, b[7 - i] ? fg_col : bg_col);
    end
  endtask : bits

  task automatic drain(input string name);
    int n;
    n = 0;
    repeat (4) @(posedge clk_sys);
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (2) @(posedge clk_sys);
    check(32'(got.size()), 32'(exp.size()), "pixel count");
    foreach (exp[i]) begin
      if (i < got.size()) begin
        check({got[i].x, got[i].y}, {exp[i].x, exp[i].y}, "pixel place");
        check({31'h0, got[i].wr}, {31'h0, exp[i].wr}, "pixel write");
        check({28'h0, got[i].be}, {28'h0, exp[i].be}, "pixel enables");
        if (exp[i].wr) begin
          check(got[i].data, exp[i].data, "pixel data");
        end
      end
    end
    got.delete();
    exp.delete();
    $display("test %s done", name);
  endtask : drain

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    check({30'h0, data_ready, busy}, 32'h2, "idle after reset");
    hbt_host_i.rd(`HBT_OFF_CTRL, v);
    check(v, `HBT_CTRL_RST, "ctrl reset");
    hbt_host_i.wr(16'h00fc, 32'hffff_ffff);
    hbt_host_i.rd(16'h00fc, v);
    check(v, 32'h0, "unmapped");
    hbt_host_i.wr(`HBT_OFF_FG, fg_col);
    hbt_host_i.wr(`HBT_OFF_BG, bg_col);
    hbt_host_i.rd(`HBT_OFF_BG, v);
    check(v, bg_col, "bg readback");
    $display("test registers done");
    // host copy with alignment bit 3 set
    hbt_host_i.setup(32'h0000_02cc, 16'h3, 16'h1, 16'h4, 16'h8);
    hbt_host_i.launch(10'h0, 16'h10, 16'h8);
    ex(16'h10, 16'h8, 1'b1, 32'h1122_3344);
    ex(16'h10, 16'h9, 1'b1, 32'h5566_7788);
    hbt_host_i.push(32'h1122_3344);
    hbt_host_i.push(32'h5566_7788);
    drain("host copy");
    for (int t = 0; t < 2; t++) begin
      hbt_host_i.setup(32'h0000_06cc, 16'h7, 16'h1, t ? 16'h0 : 16'h4, 16'h0);
      hbt_host_i.launch(10'h0, 16'h0, 16'h0);
      bits(16'h0, 16'h0, 2, 8'h80, 1'b0);
      bits(16'h0, 16'h1, 2, t ? 8'hc0 : 8'h40, 1'b0);
      if (t == 0) begin
        hbt_host_i.push(32'h0000_0080);
        hbt_host_i.push(32'h0000_0040);
      end else begin
        hbt_host_i.push(32'h0000_00b0);
      end
      drain(t ? "stride zero" : "line drop");
    end
    // packed text, second character queued while busy
    hbt_host_i.setup(32'h0000_9ecc, 16'h0, 16'h2, 16'h0, 16'h20);
    hbt_host_i.launch(10'd19, 16'h28, 16'h14);
    hbt_host_i.launch(10'd7, 16'h50, 16'h14);
    bits(16'h28, 16'h14, 5, 8'hb0, 1'b1);
    bits(16'h28, 16'h15, 5, 8'h68, 1'b1);
    bits(16'h50, 16'h14, 2, 8'hc0, 1'b1);
    bits(16'h50, 16'h15, 2, 8'h40, 1'b1);
    hbt_host_i.push(32'hffff_7fb3);
    hbt_host_i.push(32'hffff_ffdf);
    drain("packed text");
    check(32'(rows.size()), 32'd4, "pattern rows");
    foreach (rows[i]) begin
      check({16'h0, rows[i]}, 32'(i % 2), "pattern row");
    end
    // last font strip: background fill, then transparent draw of zero-padded bits
    hbt_host_i.setup(32'h0000_00cc, 16'h7, 16'h0, 16'h4, 16'h0);
    hbt_host_i.launch(10'h0, 16'h30, 16'h6);
    ex(16'h30, 16'h6, 1'b1, bg_col);
    ex(16'h34, 16'h6, 1'b1, bg_col);
    drain("strip fill");
    hbt_host_i.setup(32'h0000_0ecc, 16'h7, 16'h0, 16'h4, 16'h0);
    hbt_host_i.launch(10'h0, 16'h30, 16'h6);
    bits(16'h30, 16'h6, 2, 8'h80, 1'b1);
    hbt_host_i.push(32'h0000_0080);
    drain("strip draw");
    foreach (codes[k]) begin
      hbt_host_i.setup({16'h0, 8'ha0, codes[k]}, 16'h0, 16'h0, 16'h4, 16'h0);
      hbt_host_i.launch(10'd7, 16'h64, 16'h32);
      ex(16'h64, 16'h32, 1'b1, rop_at(codes[k], 16'h64, 16'h32));
      ex(16'h68, 16'h32, 1'b1, rop_at(codes[k], 16'h68, 16'h32));
      drain("horizontal line");
    end
    hbt_host_i.rd(`HBT_OFF_WIDTH, v);
    check(v, 32'h7, "width from count");
    hbt_host_i.setup(32'h0000_c0cc, 16'h3, 16'h0, 16'h4, 16'h0);
    hbt_host_i.launch(10'd2, 16'h8, 16'h4);
    for (int i = 0; i < 3; i++) begin
      ex(16'h8, 16'(4 + i), 1'b1, bg_col);
    end
    drain("vertical line");
    hbt_host_i.rd(`HBT_OFF_HEIGHT, v);
    check(v, 32'h2, "height from count");
    results();
  end

endmodule : tb_top
`default_nettype wire
